// file: verilog/power_state_wake_control.sv
// power-state and wake-event control
`timescale 1ns/1ps
`default_nettype none
`include "pm_wake_consts.svh"

module power_state_wake_control #(
  parameter int READY_CYCLES = `PM_READY_DEFAULT,
  parameter int PULSE_CYCLES = `PM_PULSE_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   hostRead,
  input  wire logic                   hostWrite,
  input  wire logic                   modeWrite,
  input  wire logic [1:0]             modeData,
  input  wire logic                   byteTestWrite,
  input  wire logic                   wakeStatusClear,
  input  wire logic                   wakeIntClear,
  input  wire pm_wake_pkg::wake_cfg_t cfg,
  input  wire logic                   wakeFramePin,
  input  wire logic                   carrierPin,
  output logic [1:0]                  power_state_select,
  output logic [1:0]                  wake_status_field,
  output logic                        ready,
  output logic                        writeEnable,
  output logic                        wakeInterrupt,
  output logic                        wakeIntStatus,
  output logic                        frameDetectEnable,
  output logic                        macClockEnable,
  output logic                        hostClockEnable,
  output logic                        pmClockEnable,
  output logic                        internalClockEnable,
  output logic                        eventPin,
  output logic                        eventPinOe
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  pm_wake_pkg::wake_evt_t evt;
  logic [1:0]             evtSync;

  pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({wakeFramePin, carrierPin}),
    .dout    (evtSync)
  );

  assign evt.frameSeen   = evtSync[1];
  assign evt.carrierSeen = evtSync[0];

  // ************************************************************
  // write qualification
  // ************************************************************
  // host writes land only once a read has armed them
  // hostWrite marks a real bus write, so a stray strobe is not taken
  // the wake write skips this gate
  logic writeArmed;
  logic modeWriteOk;
  logic statusClearOk;
  logic intClearOk;

  always_comb begin
    writeArmed    = writeEnable && hostWrite;
    modeWriteOk   = modeWrite && writeArmed;
    statusClearOk = wakeStatusClear && writeArmed;
    intClearOk    = wakeIntClear && writeArmed;
  end

  // ************************************************************
  // wake timing
  // ************************************************************
  // delays are clamped, so no setting breaks the ready limit or wraps a counter
  localparam int READY_LIMIT = `PM_READY_CYCLES;
  localparam int READY_USED  = (READY_CYCLES > READY_LIMIT) ? READY_LIMIT :
                               (READY_CYCLES < 1) ? 1 : READY_CYCLES;
  localparam int PULSE_MAX   = (1 << `PM_CNT_W) - 1;
  localparam int PULSE_USED  = (PULSE_CYCLES > PULSE_MAX) ? PULSE_MAX :
                               (PULSE_CYCLES < 1) ? 1 : PULSE_CYCLES;

  // ************************************************************
  // power state machine
  // ************************************************************
  pm_wake_pkg::power_state_t state;
  pm_wake_pkg::power_state_t next_state;
  logic [1:0]                next_power_state_select;
  logic                      next_ready;
  logic                      next_writeEnable;
  logic [`PM_CNT_W-1:0]      wakeCount;
  logic [`PM_CNT_W-1:0]      next_wakeCount;

  function automatic logic asleep(input pm_wake_pkg::power_state_t s);
    asleep = (s == pm_wake_pkg::STATE_D1) || (s == pm_wake_pkg::STATE_D2);
  endfunction : asleep

  // state decodes shared by gating, detection and status
  function automatic logic inLight(input pm_wake_pkg::power_state_t s);
    inLight = (s == pm_wake_pkg::STATE_D1);
  endfunction : inLight

  function automatic logic inDeep(input pm_wake_pkg::power_state_t s);
    inDeep = (s == pm_wake_pkg::STATE_D2);
  endfunction : inDeep

  always_comb begin
    next_state              = state;
    next_power_state_select = power_state_select;
    next_ready              = ready;
    next_writeEnable        = writeEnable;
    next_wakeCount          = wakeCount;
    // a write only counts once a read has armed the interface
    if (hostRead) begin
      next_writeEnable = 1'b1;
    end
    case (state)
      pm_wake_pkg::STATE_D0: begin
        // 00 and 11 name no saving state and leave the mode alone
        if (modeWriteOk) begin
          if (modeData == `PM_STATE_D1) begin
            next_state              = pm_wake_pkg::STATE_D1;
            next_power_state_select = `PM_STATE_D1;
            next_ready              = 1'b0;
            next_writeEnable        = 1'b0;
          end else if (modeData == `PM_STATE_D2) begin
            next_state              = pm_wake_pkg::STATE_D2;
            next_power_state_select = `PM_STATE_D2;
            next_ready              = 1'b0;
            next_writeEnable        = 1'b0;
          end
        end
      end
      pm_wake_pkg::STATE_D1, pm_wake_pkg::STATE_D2: begin
        // the wake write is honoured even without a prior read
        if (byteTestWrite) begin
          next_state              = pm_wake_pkg::STATE_WAKING;
          next_power_state_select = `PM_STATE_D0;
          next_wakeCount          = READY_USED[`PM_CNT_W-1:0];
          next_writeEnable        = 1'b0;
        end
      end
      pm_wake_pkg::STATE_WAKING: begin
        // host clocks run again here so ready can be polled
        if (wakeCount <= 20'h00001) begin
          next_state = pm_wake_pkg::STATE_D0;
          next_ready = 1'b1;
          next_wakeCount = '0;
        end else begin
          next_wakeCount = wakeCount - 20'h00001;
        end
      end
      default: begin
        next_state = pm_wake_pkg::STATE_D0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state              <= pm_wake_pkg::STATE_D0;
      power_state_select <= `PM_STATE_D0;
      ready              <= 1'b1;
      writeEnable        <= 1'b0;
      wakeCount          <= '0;
    end else begin
      state              <= next_state;
      power_state_select <= next_power_state_select;
      ready              <= next_ready;
      writeEnable        <= next_writeEnable;
      wakeCount          <= next_wakeCount;
    end
  end

  // ************************************************************
  // clock gating controls
  // ************************************************************
  // configuration registers live outside and keep running, so they survive sleep
  // enables are decoded from state, so they drop on the entry edge itself
  always_comb begin
    macClockEnable      = !asleep(state);
    hostClockEnable     = !asleep(state);
    pmClockEnable       = !inDeep(state);
    internalClockEnable = !inDeep(state);
    frameDetectEnable   = inLight(state);
  end

  // ************************************************************
  // wake status and interrupt
  // ************************************************************
  logic [1:0] next_wake_status_field;
  logic       next_wakeIntStatus;
  logic       frameHit;
  logic       carrierHit;
  logic       wakeSource;

  always_comb begin
    // level compare catches carrier already present at entry
    frameHit   = inLight(state) && evt.frameSeen && cfg.wakeLanEnable;
    carrierHit = inDeep(state) && evt.carrierSeen && cfg.energyDetectWakeEnable;
    next_wake_status_field = wake_status_field;
    // a cleared field lets the interrupt and pin fall
    if (statusClearOk) begin
      next_wake_status_field = `PM_WAKE_NONE;
    end
    // set wins over a clear in the same cycle
    if (frameHit) begin
      next_wake_status_field = `PM_WAKE_FRAME;
    end else if (carrierHit) begin
      next_wake_status_field = `PM_WAKE_ENERGY;
    end
  end

  // internal wake level tracks status gated by its matching enable
  always_comb begin
    wakeSource = (wake_status_field == `PM_WAKE_FRAME && cfg.wakeLanEnable)
              || (wake_status_field == `PM_WAKE_ENERGY && cfg.energyDetectWakeEnable);
    wakeInterrupt = wakeSource;
    next_wakeIntStatus = wakeIntStatus;
    // a clear while the source stands is dropped, not queued
    if (intClearOk && !wakeSource) begin
      next_wakeIntStatus = 1'b0;
    end
    if (wakeSource) begin
      next_wakeIntStatus = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_status_field <= `PM_WAKE_NONE;
      wakeIntStatus     <= 1'b0;
    end else begin
      wake_status_field <= next_wake_status_field;
      wakeIntStatus     <= next_wakeIntStatus;
    end
  end

  // ************************************************************
  // event pin trigger
  // ************************************************************
  logic hitSeen;
  logic next_hitSeen;

  // a one-cycle hit would expire before hold rises, so it is held a cycle
  // a standing hit retriggers the pulse once it ends
  always_comb begin
    next_hitSeen = frameHit || carrierHit;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hitSeen <= 1'b0;
    end else begin
      hitSeen <= next_hitSeen;
    end
  end

  // ************************************************************
  // external event pin
  // ************************************************************
  logic pinActive;

  event_pin_driver #(.PULSE_CYCLES(PULSE_USED)) u_pin (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .trigger     (hitSeen),
    .hold        (wakeSource && cfg.eventPinEnable),
    .pulseSelect (cfg.eventPinPulseSelect),
    .pinActive   (pinActive)
  );

  // open-drain style: drive only while active
  always_comb begin
    eventPin   = pinActive;
    eventPinOe = pinActive;
  end

endmodule : power_state_wake_control

`default_nettype wire

// file: verilog/pm_wake_consts.svh
// constants for the power-state and wake-event logic
`ifndef PM_WAKE_CONSTS_SVH
`define PM_WAKE_CONSTS_SVH

`define PM_STATE_D0        2'h0
`define PM_STATE_D1        2'h1
`define PM_STATE_D2        2'h2
`define PM_WAKE_NONE       2'h0
`define PM_WAKE_ENERGY     2'h1
`define PM_WAKE_FRAME      2'h2
`define PM_CLK_HZ          10000000
`define PM_PULSE_MS        50
`define PM_READY_MAX_MS    2
`define PM_PULSE_CYCLES    ((`PM_PULSE_MS * `PM_CLK_HZ) / 1000)
`define PM_READY_CYCLES    ((`PM_READY_MAX_MS * `PM_CLK_HZ) / 1000)
`define PM_READY_DEFAULT   16
`define PM_CNT_W           20

`endif

// file: verilog/pm_wake_pkg.sv
// types shared by the power-state and wake-event logic
package pm_wake_pkg;

  typedef enum logic [1:0] {
    STATE_D0,
    STATE_D1,
    STATE_D2,
    STATE_WAKING
  } power_state_t;

  typedef struct packed {
    logic       wakeLanEnable;
    logic       energyDetectWakeEnable;
    logic       eventPinEnable;
    logic       eventPinPulseSelect;
  } wake_cfg_t;

  typedef struct packed {
    logic       frameSeen;
    logic       carrierSeen;
  } wake_evt_t;

endpackage : pm_wake_pkg

// file: verilog/pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: verilog/event_pin_driver.sv
// event pin driver: pulsed or static drive
`timescale 1ns/1ps
`default_nettype none
`include "pm_wake_consts.svh"

module event_pin_driver #(
  parameter int PULSE_CYCLES = `PM_PULSE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic trigger,
  input  wire logic hold,
  input  wire logic pulseSelect,
  output logic      pinActive
);

  logic [`PM_CNT_W-1:0] count;
  logic [`PM_CNT_W-1:0] next_count;
  logic                 next_pinActive;

  // free clock domain, so the pulse finishes while host side is gated
  always_comb begin
    next_count     = count;
    next_pinActive = pinActive;
    if (!hold) begin
      next_pinActive = 1'b0;
      next_count     = '0;
    end else if (trigger && !pinActive) begin
      next_pinActive = 1'b1;
      next_count     = PULSE_CYCLES[`PM_CNT_W-1:0];
    end else if (pinActive && pulseSelect) begin
      if (count <= 20'h00001) begin
        next_pinActive = 1'b0;
        next_count     = '0;
      end else begin
        next_count = count - 20'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count     <= '0;
      pinActive <= 1'b0;
    end else begin
      count     <= next_count;
      pinActive <= next_pinActive;
    end
  end

endmodule : event_pin_driver

`default_nettype wire

// file: sim/host_model.sv
// host-side model: bus strobes toward the power-state block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk_sys,
  output logic      hostRead,
  output logic      hostWrite,
  output logic      modeWrite,
  output logic [1:0] modeData,
  output logic      byteTestWrite,
  output logic      wakeStatusClear,
  output logic      wakeIntClear
);
  // ************************************
  // one-cycle strobes, idle cycle between
  // ************************************
  initial {hostRead, hostWrite, modeWrite, modeData, byteTestWrite, wakeStatusClear, wakeIntClear} = '0;
  task automatic strobe(input logic [4:0] s, input logic [1:0] d);
    @(posedge clk_sys);
    #10;
    {hostRead, modeWrite, byteTestWrite, wakeStatusClear, wakeIntClear} = s;
    hostWrite = |s[3:0];
    modeData = d;
    @(posedge clk_sys);
    #10;
    {hostRead, hostWrite, modeWrite, byteTestWrite, wakeStatusClear, wakeIntClear} = '0;
  endtask : strobe
  task automatic readArm(); strobe(5'h10, 2'h0); endtask : readArm
  // phy powerdown bit lives outside this block, taken as already set
  task automatic setMode(input logic [1:0] m); strobe(5'h08, m); endtask : setMode
  task automatic wakeWrite(); strobe(5'h04, 2'h0); endtask : wakeWrite
  task automatic clrStatus(); strobe(5'h02, 2'h0); endtask : clrStatus
  task automatic clrInt(); strobe(5'h01, 2'h0); endtask : clrInt
endmodule : host_model
`default_nettype wire

// file: sim/power_state_wake_control_checker.sv
// assertions on the power-state and wake ports
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_control_checker (
  input wire logic clk_sys, rst, hostWrite, modeWrite, byteTestWrite, wakeStatusClear, writeEnable, ready,
  input wire logic [1:0] modeData, power_state_select, wake_status_field,
  input wire pm_wake_pkg::wake_cfg_t cfg,
  input wire logic wakeFramePin, carrierPin, wakeInterrupt, wakeIntStatus, frameDetectEnable,
  input wire logic macClockEnable, hostClockEnable, pmClockEnable, internalClockEnable, eventPin
);
  // ************************************
  // properties
  // ************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_enter_sleep: assert property (
    modeWrite && hostWrite && writeEnable && ready && power_state_select == 2'h0 && modeData inside {2'h1, 2'h2}
    |=> power_state_select == $past(modeData) && !ready) else $error("sleep entry wrong");
  a_unarmed_write: assert property (
    modeWrite && !writeEnable && !byteTestWrite |=> $stable(power_state_select)) else $error("write not ignored");
  a_unarmed_clear: assert property (
    wakeStatusClear && !writeEnable && power_state_select == 2'h0 |=> $stable(wake_status_field))
    else $error("clear not ignored");
  a_wake_write: assert property (
    byteTestWrite && power_state_select != 2'h0 |=> power_state_select == 2'h0 && !ready ##[1:1000] ready)
    else $error("wake write wrong");
  a_sleep_ready: assert property (
    power_state_select != 2'h0 |-> !ready) else $error("ready set in sleep");
  a_d1_clocks: assert property (
    power_state_select == 2'h1 |-> frameDetectEnable && internalClockEnable && !macClockEnable && !hostClockEnable)
    else $error("d1 clocks wrong");
  a_d2_clocks: assert property (
    power_state_select == 2'h2 |-> !(macClockEnable || hostClockEnable || pmClockEnable || internalClockEnable))
    else $error("d2 clocks wrong");
  a_frame_status: assert property (
    (power_state_select == 2'h1 && cfg.wakeLanEnable && wakeFramePin) [*4] |-> wake_status_field == 2'h2)
    else $error("frame status wrong");
  a_carrier_status: assert property (
    (power_state_select == 2'h2 && cfg.energyDetectWakeEnable && carrierPin && !wakeFramePin) [*4]
    |-> wake_status_field == 2'h1) else $error("carrier status wrong");
  a_int_source: assert property (
    wakeInterrupt |-> wake_status_field != 2'h0) else $error("interrupt without status");
  a_int_sticky: assert property (
    wakeInterrupt |=> wakeIntStatus) else $error("interrupt status not held");
  a_pin_release: assert property (
    !cfg.eventPinEnable [*3] |-> !eventPin) else $error("event pin not released");
endmodule : power_state_wake_control_checker
bind power_state_wake_control power_state_wake_control_checker i_chk (.clk_sys, .rst, .hostWrite, .modeWrite,
  .byteTestWrite, .wakeStatusClear,
  .writeEnable, .ready, .modeData, .power_state_select, .wake_status_field, .cfg, .wakeFramePin, .carrierPin,
  .wakeInterrupt, .wakeIntStatus, .frameDetectEnable, .macClockEnable, .hostClockEnable, .pmClockEnable,
  .internalClockEnable, .eventPin);
`default_nettype wire

// file: sim/power_state_wake_control_tb_top.sv
// testbench for the power-state and wake control
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_control_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hostRead, hostWrite, modeWrite, byteTestWrite, wakeStatusClear, wakeIntClear, eventPinOe;
  logic [1:0] modeData, power_state_select, wake_status_field;
  pm_wake_pkg::wake_cfg_t cfg;
  logic wakeFramePin;
  logic carrierPin;
  logic ready, writeEnable, wakeInterrupt, wakeIntStatus, frameDetectEnable, eventPin;
  logic macClockEnable, hostClockEnable, pmClockEnable, internalClockEnable;
  int err_count = 0;
  int n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  host_model i_host (.clk_sys, .hostRead, .hostWrite, .modeWrite, .modeData, .byteTestWrite, .wakeStatusClear,
    .wakeIntClear);
  // short pulse and ready counts keep the run brief
  power_state_wake_control #(.READY_CYCLES(16), .PULSE_CYCLES(20)) i_dut (.clk_sys, .rst, .hostRead, .hostWrite,
    .modeWrite, .modeData, .byteTestWrite, .wakeStatusClear, .wakeIntClear, .cfg, .wakeFramePin, .carrierPin,
    .power_state_select, .wake_status_field, .ready, .writeEnable, .wakeInterrupt, .wakeIntStatus,
    .frameDetectEnable, .macClockEnable, .hostClockEnable, .pmClockEnable, .internalClockEnable, .eventPin,
    .eventPinOe);
  // ************************************
  // helpers
  // ************************************
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic waitHigh(ref logic s, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #10;
      if (s === 1'b1) return;
    end
    err_count++; // bounded wait ran out
    wrap_up();
  endtask : waitHigh
  // ************************************
  // scenarios
  // ************************************
  task automatic scn_frame_wake();
    int n;
    cfg = 4'hB;
    i_host.readArm();
    i_host.setMode(2'h1);
    check({ready, power_state_select}, 8'h1);
    wakeFramePin = 1'b1;
    waitHigh(eventPin, 10);
    check({wake_status_field, wakeIntStatus}, 8'h5);
    wakeFramePin = 1'b0;
    n = 0;
    while (eventPin === 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #10;
      if (eventPin === 1'b1) n++;
    end
    check(8'(n), 8'd19);
    i_host.wakeWrite();
    check({ready, power_state_select}, 8'h0);
    waitHigh(ready, 20);
    i_host.setMode(2'h1);
    check(power_state_select, 8'h0);
    i_host.clrStatus();
    check(wake_status_field, 8'h2);
    i_host.readArm();
    i_host.clrInt();
    check(wakeIntStatus, 8'h1);
    i_host.clrStatus();
    check({wake_status_field, wakeInterrupt}, 8'h0);
    i_host.clrInt();
    check(wakeIntStatus, 8'h0);
  endtask : scn_frame_wake
  task automatic scn_carrier_wake();
    cfg = 4'h6;
    carrierPin = 1'b1;
    i_host.readArm();
    i_host.setMode(2'h3);
    check(power_state_select, 8'h0);
    i_host.setMode(2'h2);
    repeat (8) @(posedge clk_sys);
    #10;
    check({wake_status_field, eventPin}, 8'h3);
    repeat (30) @(posedge clk_sys);
    #10;
    check(eventPin, 8'h1);
    cfg = 4'h2;
    repeat (4) @(posedge clk_sys);
    #10;
    check({wakeInterrupt, eventPin}, 8'h0);
    carrierPin = 1'b0;
    i_host.wakeWrite();
    waitHigh(ready, 20);
    check(power_state_select, 8'h0);
  endtask : scn_carrier_wake
  initial begin
    cfg = '0;
    wakeFramePin = 1'b0;
    carrierPin = 1'b0;
    repeat (16) @(posedge clk_sys);
    #10;
    rst = 1'b0;
    check({ready, writeEnable, power_state_select}, 8'h8);
    scn_frame_wake();
    scn_carrier_wake();
    wrap_up();
  end
endmodule : power_state_wake_control_tb_top
`default_nettype wire
